// [shared/usbrx_regs.svh]
// Register offsets, field positions, reset values and bounds
`ifndef USBRX_REGS_SVH
`define USBRX_REGS_SVH
`define USBRX_OFS_PEEK     8'h1c
`define USBRX_OFS_POP      8'h20
`define USBRX_OFS_RXLEN    8'h24
`define USBRX_OFS_TXLEN    8'h28
`define USBRX_OFS_INTF     8'h40
`define USBRX_OFS_INTEN    8'h44
`define USBRX_RST_RXLEN    32'h00000200
`define USBRX_RST_TXLEN    32'h02000200
`define USBRX_RST_ZERO     32'h00000000
`define USBRX_CODE_MSB     20
`define USBRX_CODE_LSB     17
`define USBRX_PID_MSB      16
`define USBRX_PID_LSB      15
`define USBRX_BCNT_MSB     14
`define USBRX_BCNT_LSB     4
`define USBRX_NUM_MSB      3
`define USBRX_NUM_LSB      0
`define USBRX_RSV_MSB      31
`define USBRX_RSV_LSB      21
`define USBRX_BIT_RXNE     4
`define USBRX_BIT_EVT      0
`define USBRX_INT_MASK     32'h00000011
`define USBRX_H_IN_DATA    4'h2
`define USBRX_H_IN_DONE    4'h3
`define USBRX_H_TOG_ERR    4'h5
`define USBRX_H_HALTED     4'h7
`define USBRX_D_GONAK      4'h1
`define USBRX_D_OUT_DATA   4'h2
`define USBRX_D_OUT_DONE   4'h3
`define USBRX_D_SETUP_DONE 4'h4
`define USBRX_D_SETUP_DATA 4'h6
`define USBRX_PID_DATA0    2'h0
`define USBRX_PID_DATA1    2'h2
`define USBRX_RX_MIN       16'h0001
`define USBRX_RX_MAX       16'h0400
`define USBRX_HTX_MIN      16'h0001
`define USBRX_HTX_MAX      16'h0400
`define USBRX_DTX_MIN      16'h0010
`define USBRX_DTX_MAX      16'h008c
`endif

// [shared/usbrx_pkg.sv]
// Types of the receive status and FIFO sizing block
package usbrx_pkg;
    typedef logic [3:0]  usbrx_code_t;
    typedef logic [1:0]  usbrx_pid_t;
    typedef logic [10:0] usbrx_bcnt_t;
    typedef logic [3:0]  usbrx_num_t;
    typedef logic [15:0] usbrx_half_t;
    typedef logic [7:0]  usbrx_addr_t;
    typedef logic [31:0] usbrx_word_t;
endpackage

// [core/usbrx_core.sv]
// Receive status queue, FIFO sizing registers and interrupt logic
// Contract
// - Peek read returns top, keeps entry
// - Pop read returns top, removes entry
// - Host status codes in bits 20:17
// - Host pop of 3,5,7 raises interrupt
// - Device status codes in bits 20:17
// - Device codes 1,3,4 raise interrupt
// - Bits 16:15 carry data PID
// - Bits 14:4 carry byte count
// - Bits 3:0 carry channel or endpoint
// - Receive depth in words, 1 to 1024
// - Host transmit depth 1 to 1024
// - Host transmit start in low half
// - Endpoint-0 depth 16 to 140
// - Endpoint-0 start in low half
// - Not-empty interrupt gated by enable bit 4
`timescale 1ns/100ps
`default_nettype none
`include "usbrx_regs.svh"

module usbrx_core #(
    parameter int DEPTH = 16
) (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               host_mode,
    input  wire logic               push_valid,
    input  wire usbrx_pkg::usbrx_code_t push_code,
    input  wire usbrx_pkg::usbrx_pid_t  push_pid,
    input  wire usbrx_pkg::usbrx_bcnt_t push_bcnt,
    input  wire usbrx_pkg::usbrx_num_t  push_num,
    output logic                    push_ready,
    input  wire usbrx_pkg::usbrx_addr_t addr,
    input  wire usbrx_pkg::usbrx_word_t wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output usbrx_pkg::usbrx_word_t  rdata,
    output logic                    irq,
    output logic                    rx_fifo_empty,
    output usbrx_pkg::usbrx_half_t  rx_fifo_depth,
    output usbrx_pkg::usbrx_half_t  tx_depth,
    output usbrx_pkg::usbrx_half_t  tx_start
);
    import usbrx_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    // Depth must be a power of two so the pointers wrap by themselves
    logic [20:0]   mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    usbrx_half_t   rx_depth_reg;
    usbrx_half_t   tx_depth_reg;
    usbrx_half_t   tx_start_reg;
    usbrx_word_t   intf_reg;
    usbrx_word_t   inten_reg;
    usbrx_word_t   rdata_reg;
    usbrx_word_t   rdata_next;
    usbrx_word_t   top_word;
    usbrx_word_t   evt_set;
    logic          full;
    logic          empty;
    logic          push_fire;
    logic          pop_fire;
    logic          top_irq;
    usbrx_code_t   top_code;

    function automatic usbrx_half_t clamp16(
        input usbrx_half_t v,
        input usbrx_half_t lo,
        input usbrx_half_t hi
    );
        usbrx_half_t r;
        r = v;
        if (v < lo)
        begin
            r = lo;
        end
        else if (v > hi)
        begin
            r = hi;
        end
        return r;
    endfunction

    function automatic logic code_irq(
        input logic        hmode,
        input usbrx_code_t c
    );
        logic r;
        r = 1'b0;
        if (hmode)
        begin
            r = (c == `USBRX_H_IN_DONE) || (c == `USBRX_H_TOG_ERR) ||
                (c == `USBRX_H_HALTED);
        end
        else
        begin
            r = (c == `USBRX_D_GONAK) || (c == `USBRX_D_OUT_DONE) ||
                (c == `USBRX_D_SETUP_DONE);
        end
        return r;
    endfunction

    assign full       = (count_reg == CW'(DEPTH));
    assign empty      = (count_reg == '0);
    assign push_ready = !full;
    assign push_fire  = push_valid && !full;
    assign pop_fire   = rd && (addr == `USBRX_OFS_POP) && !empty;

    assign top_code = mem[rd_ptr_reg][`USBRX_CODE_MSB:`USBRX_CODE_LSB];

    always_comb
    begin
        top_word = '0;
        if (!empty)
        begin
            top_word[20:0] = mem[rd_ptr_reg];
        end
    end

    assign top_irq = code_irq(host_mode, top_code);

    always_comb
    begin
        evt_set = '0;
        evt_set[`USBRX_BIT_EVT]  = pop_fire && top_irq;
        evt_set[`USBRX_BIT_RXNE] = !empty;
    end

    // Entry storage, no reset needed for data
    always_ff @(posedge mclk)
    begin
        if (push_fire)
        begin
            mem[wr_ptr_reg] <= {push_code, push_pid, push_bcnt, push_num};
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_reg <= '0;
        end
        else if (push_fire)
        begin
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rd_ptr_reg <= '0;
        end
        else if (pop_fire)
        begin
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            count_reg <= '0;
        end
        else if (push_fire && !pop_fire)
        begin
            count_reg <= count_reg + CW'(1);
        end
        else if (pop_fire && !push_fire)
        begin
            count_reg <= count_reg - CW'(1);
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rx_depth_reg <= 16'(`USBRX_RST_RXLEN);
        end
        else if (wr && (addr == `USBRX_OFS_RXLEN))
        begin
            rx_depth_reg <= clamp16(wdata[15:0], `USBRX_RX_MIN, `USBRX_RX_MAX);
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tx_depth_reg <= 16'(`USBRX_RST_TXLEN >> 16);
        end
        else if (wr && (addr == `USBRX_OFS_TXLEN))
        begin
            if (host_mode)
            begin
                tx_depth_reg <= clamp16(wdata[31:16], `USBRX_HTX_MIN,
                                        `USBRX_HTX_MAX);
            end
            else
            begin
                tx_depth_reg <= clamp16(wdata[31:16], `USBRX_DTX_MIN,
                                        `USBRX_DTX_MAX);
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tx_start_reg <= 16'(`USBRX_RST_TXLEN & 32'h0000ffff);
        end
        else if (wr && (addr == `USBRX_OFS_TXLEN))
        begin
            tx_start_reg <= wdata[15:0];
        end
    end

    // Sticky flags, a new event beats a same-cycle clear
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            intf_reg <= `USBRX_RST_ZERO;
        end
        else if (wr && (addr == `USBRX_OFS_INTF))
        begin
            intf_reg <= ((intf_reg & ~wdata) | evt_set) & `USBRX_INT_MASK;
        end
        else
        begin
            intf_reg <= (intf_reg | evt_set) & `USBRX_INT_MASK;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            inten_reg <= `USBRX_RST_ZERO;
        end
        else if (wr && (addr == `USBRX_OFS_INTEN))
        begin
            inten_reg <= wdata & `USBRX_INT_MASK;
        end
    end

    assign irq = |(intf_reg & inten_reg);

    // Unmapped offsets read as zero
    always_comb
    begin
        rdata_next = '0;
        if (rd)
        begin
            case (addr)
                `USBRX_OFS_PEEK:  rdata_next = top_word;
                `USBRX_OFS_POP:   rdata_next = top_word;
                `USBRX_OFS_RXLEN: rdata_next = {16'h0000, rx_depth_reg};
                `USBRX_OFS_TXLEN: rdata_next = {tx_depth_reg, tx_start_reg};
                `USBRX_OFS_INTF:  rdata_next = intf_reg;
                `USBRX_OFS_INTEN: rdata_next = inten_reg;
                default:          rdata_next = '0;
            endcase
        end
    end

    // Data stands only in the cycle after the read
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rdata_reg <= '0;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata         = rdata_reg;
    assign rx_fifo_empty = empty;
    assign rx_fifo_depth = rx_depth_reg;
    assign tx_depth      = tx_depth_reg;
    assign tx_start      = tx_start_reg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    peek_keeps_a: assert property (
        rd && addr == `USBRX_OFS_PEEK && !push_fire |=> count_reg == $past(count_reg))
        else $error("Peek changed the entry count");
    peek_data_a: assert property (
        rd && addr == `USBRX_OFS_PEEK |=> rdata == $past(top_word))
        else $error("Peek data wrong");
    pop_removes_a: assert property (
        pop_fire && !push_fire |=> count_reg == $past(count_reg) - CW'(1))
        else $error("Pop did not remove the entry");
    pop_data_a: assert property (
        rd && addr == `USBRX_OFS_POP |=> rdata == $past(top_word))
        else $error("Pop data wrong");
    field_layout_a: assert property (
        push_fire && empty |=> top_word[14:4] == $past(push_bcnt)
            && top_word[16:15] == $past(push_pid) && top_word[3:0] == $past(push_num)
            && top_word[20:17] == $past(push_code))
        else $error("Entry field layout wrong");
    // Only the status views have reserved upper bits; the transmit length word uses them
    rsvd_zero_a: assert property (
        rd && (addr == `USBRX_OFS_PEEK || addr == `USBRX_OFS_POP) |=>
            rdata[`USBRX_RSV_MSB:`USBRX_RSV_LSB] == '0)
        else $error("Reserved status bits set");
    host_evt_a: assert property (
        pop_fire && host_mode && (top_code == `USBRX_H_IN_DONE
            || top_code == `USBRX_H_TOG_ERR || top_code == `USBRX_H_HALTED)
            |=> intf_reg[`USBRX_BIT_EVT])
        else $error("Host event lost");
    host_noevt_a: assert property (
        pop_fire && host_mode && top_code == `USBRX_H_IN_DATA && !intf_reg[0]
            && !(wr && addr == `USBRX_OFS_INTF) |=> !intf_reg[0])
        else $error("Data entry raised an event");
    dev_evt_a: assert property (
        pop_fire && !host_mode && top_code == `USBRX_D_SETUP_DONE |=> intf_reg[0])
        else $error("Device event lost");
    dev_noevt_a: assert property (
        pop_fire && !host_mode && (top_code == `USBRX_D_OUT_DATA
            || top_code == `USBRX_D_SETUP_DATA) && !intf_reg[0]
            && !(wr && addr == `USBRX_OFS_INTF) |=> !intf_reg[0])
        else $error("Device data entry raised an event");
    rx_range_a: assert property (
        rx_fifo_depth >= `USBRX_RX_MIN && rx_fifo_depth <= `USBRX_RX_MAX)
        else $error("Receive depth out of range");
    htx_range_a: assert property (
        wr && addr == `USBRX_OFS_TXLEN && host_mode |=>
            tx_depth >= `USBRX_HTX_MIN && tx_depth <= `USBRX_HTX_MAX)
        else $error("Host transmit depth out of range");
    dtx_range_a: assert property (
        wr && addr == `USBRX_OFS_TXLEN && !host_mode |=>
            tx_depth >= `USBRX_DTX_MIN && tx_depth <= `USBRX_DTX_MAX)
        else $error("Endpoint-0 depth out of range");
    tx_start_a: assert property (
        wr && addr == `USBRX_OFS_TXLEN |=> tx_start == $past(wdata[15:0]))
        else $error("Transmit start not stored");
    // A same-cycle write to the enable may legally drop the level
    rxne_irq_a: assert property (
        !empty && inten_reg[`USBRX_BIT_RXNE] && !(wr && addr == `USBRX_OFS_INTEN) |=> irq)
        else $error("Not-empty interrupt missing");
    rxne_flag_a: assert property (
        !empty |=> intf_reg[`USBRX_BIT_RXNE])
        else $error("Not-empty flag missing");

    pop_seen_c: cover property (pop_fire && top_irq);
    full_seen_c: cover property (push_valid && full);
    irq_seen_c: cover property ($rose(irq));
    both_seen_c: cover property (push_fire && pop_fire);
endmodule
`default_nettype wire

// [tb/test_usbrx_core.sv]
// Self-checking bench of the receive status and FIFO sizing block
`timescale 1ns/100ps
`default_nettype none

module test_usbrx_core;
    import usbrx_pkg::*;
    logic        mclk;
    logic        rst;
    logic        host_mode;
    logic        push_valid;
    usbrx_code_t push_code;
    usbrx_pid_t  push_pid;
    usbrx_bcnt_t push_bcnt;
    usbrx_num_t  push_num;
    logic        push_ready;
    usbrx_addr_t addr;
    usbrx_word_t wdata;
    logic        wr;
    logic        rd;
    usbrx_word_t rdata;
    logic        irq;
    logic        rx_fifo_empty;
    usbrx_half_t rx_fifo_depth;
    usbrx_half_t tx_depth;
    usbrx_half_t tx_start;
    usbrx_word_t rv;
    int          miscompares;
    int          samples_checked;

    // Four entries make the full queue cheap to reach
    usbrx_core #(.DEPTH(4)) dut (.mclk(mclk), .rst(rst), .host_mode(host_mode),
        .push_valid(push_valid), .push_code(push_code), .push_pid(push_pid),
        .push_bcnt(push_bcnt), .push_num(push_num), .push_ready(push_ready),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .rx_fifo_empty(rx_fifo_empty), .rx_fifo_depth(rx_fifo_depth),
        .tx_depth(tx_depth), .tx_start(tx_start));

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic give_verdict;
        begin
            $display("checks %0d mismatches %0d", samples_checked, miscompares);
            if (miscompares == 0 && samples_checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    task automatic chk(input string n, input usbrx_word_t e, input usbrx_word_t g);
        begin
            samples_checked++;
            if (g !== e)
            begin
                miscompares++;
                $display("wrong value %s expected %h seen %h", n, e, g);
            end
        end
    endtask

    task automatic wreg(input usbrx_addr_t a, input usbrx_word_t d);
        begin
            @(posedge mclk);
            addr  <= a;
            wdata <= d;
            wr    <= 1'b1;
            @(posedge mclk);
            wr    <= 1'b0;
        end
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rreg(input usbrx_addr_t a);
        begin
            @(posedge mclk);
            addr <= a;
            rd   <= 1'b1;
            @(posedge mclk);
            rd   <= 1'b0;
            #1;
            rv = rdata;
        end
    endtask

    // Expected entry word: code, pid from code parity, count, number
    function automatic usbrx_word_t ent(input usbrx_code_t c, input usbrx_num_t n);
        ent = {11'h000, c, (c[0] ? 2'h2 : 2'h0), c, 3'h0, n, n};
    endfunction

    task automatic push(input usbrx_code_t c, input usbrx_num_t n);
        int k;
        begin
            k = 0;
            #1;
            while (push_ready !== 1'b1)
            begin
                @(posedge mclk);
                #1;
                k++;
                if (k > 20)
                begin
                    miscompares++;
                    give_verdict();
                end
            end
            @(posedge mclk);
            push_valid <= 1'b1;
            push_code  <= c;
            push_pid   <= c[0] ? 2'h2 : 2'h0;
            push_bcnt  <= {c, 3'h0, n};
            push_num   <= n;
            @(posedge mclk);
            push_valid <= 1'b0;
        end
    endtask

    task automatic t_reset;
        begin
            rreg(8'h24);
            chk("rx len reset", 32'h00000200, rv);
            rreg(8'h28);
            chk("tx len reset", 32'h02000200, rv);
            rreg(8'h1c);
            chk("peek reset", 32'h0, rv);
            rreg(8'h20);
            chk("pop reset", 32'h0, rv);
            wreg(8'h30, 32'hffffffff);
            rreg(8'h30);
            chk("unmapped", 32'h0, rv);
            chk("depth out", 32'h200, {16'h0, rx_fifo_depth});
        end
    endtask

    task automatic t_codes(input logic h);
        logic        e;
        usbrx_code_t c;
        begin
            @(posedge mclk);
            host_mode <= h;
            wreg(8'h44, 32'h1);
            for (int i = 1; i < 8; i++)
            begin
                c = i[3:0];
                e = h ? (c == 3 || c == 5 || c == 7) : (c == 1 || c == 3 || c == 4);
                if (c == 2 || e || (!h && c == 6))
                begin
                    push(c, ~c);
                    rreg(8'h1c);
                    chk("peek", ent(c, ~c), rv);
                    rreg(8'h1c);
                    chk("peek again", ent(c, ~c), rv);
                    rreg(8'h20);
                    chk("pop", ent(c, ~c), rv);
                    rreg(8'h40);
                    chk("event flag", {31'h0, e}, rv & 32'h1);
                    chk("event irq", {31'h0, e}, {31'h0, irq});
                    wreg(8'h40, 32'h11);
                end
            end
        end
    endtask

    task automatic t_full;
        begin
            for (int i = 0; i < 4; i++)
                push(4'h2, i[3:0]);
            #1;
            chk("ready full", 32'h0, {31'h0, push_ready});
            // An offer while full must be refused and leave no trace
            @(posedge mclk);
            push_valid <= 1'b1;
            push_code  <= 4'h6;
            @(posedge mclk);
            push_valid <= 1'b0;
            for (int i = 0; i < 4; i++)
            begin
                rreg(8'h20);
                chk("pop order", ent(4'h2, i[3:0]), rv);
            end
            rreg(8'h20);
            chk("pop empty", 32'h0, rv);
            chk("empty", 32'h1, {31'h0, rx_fifo_empty});
            wreg(8'h40, 32'h11);
        end
    endtask

    task automatic t_rxne;
        begin
            wreg(8'h44, 32'h10);
            push(4'h2, 4'h5);
            repeat (2) @(posedge mclk);
            #1;
            chk("ne irq", 32'h1, {31'h0, irq});
            rreg(8'h40);
            chk("ne flag", 32'h10, rv);
            wreg(8'h44, 32'h0);
            #1;
            chk("ne masked", 32'h0, {31'h0, irq});
            rreg(8'h20);
            wreg(8'h40, 32'h11);
            wreg(8'h44, 32'h10);
            #1;
            chk("ne cleared", 32'h0, {31'h0, irq});
        end
    endtask

    task automatic t_len;
        begin
            @(posedge mclk);
            host_mode <= 1'b1;
            wreg(8'h24, 32'h0);
            rreg(8'h24);
            chk("rx min", 32'h1, rv);
            wreg(8'h24, 32'h401);
            rreg(8'h24);
            chk("rx max", 32'h400, rv);
            wreg(8'h24, 32'h123);
            #1;
            chk("rx out", 32'h123, {16'h0, rx_fifo_depth});
            wreg(8'h28, 32'h00000140);
            rreg(8'h28);
            chk("host tx min", 32'h00010140, rv);
            chk("host start", 32'h140, {16'h0, tx_start});
            wreg(8'h28, 32'h04010180);
            rreg(8'h28);
            chk("host tx max", 32'h04000180, rv);
            @(posedge mclk);
            host_mode <= 1'b0;
            wreg(8'h28, 32'h000f0200);
            rreg(8'h28);
            chk("ep0 min", 32'h00100200, rv);
            wreg(8'h28, 32'h008d0300);
            rreg(8'h28);
            chk("ep0 max", 32'h008c0300, rv);
            chk("ep0 out", 32'h8c, {16'h0, tx_depth});
        end
    endtask

    initial
    begin
        rst = 1'b1;
        host_mode = 1'b1;
        push_valid = 1'b0;
        push_code = 4'h0;
        push_pid = 2'h0;
        push_bcnt = 11'h000;
        push_num = 4'h0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        miscompares = 0;
        samples_checked = 0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_codes(1'b1);
        t_codes(1'b0);
        t_full();
        t_rxne();
        t_len();
        give_verdict();
    end
endmodule

`default_nettype wire
